// [logic/rdw_reset_watchdog.sv]
// Reset latch, reset delay counter, watchdog with prescaler and reset-cause flags
//
// Overview of operation
// - Unprogrammed reset-pin fuse makes the shared pin an active-low reset.
// - Programmed fuse ties internal reset inactive and gives the pin to GPIO.
// - Power-up sets the reset latch and clears the delay counter.
// - Delay counts only while reset input is high; expiry clears the latch.
// - Core stays in reset whenever the delay counter is active.
// - Delay is 1.125 ms after power-up, 10 us after later resets.
// - Delay counter advances only while the latch is set, clocked by pclk.
// - Power-on, pin reset, watchdog and pin-change wake all start the delay.
// - Watchdog keeps counting while the core sleeps.
// - Watchdog expiry resets the device, awake or asleep.
// - Watchdog reset clears the active-low timeout flag, status bit 4.
// - Watchdog fuse at zero disables the watchdog for good.
// - Without prescaler the watchdog expires after 18 ms.
// - Option register assigns a prescaler extending timeout up to 1:128.
// - Clear-watchdog zeroes counter and assigned prescaler.
// - Sleep zeroes counter and assigned prescaler for maximum sleep time.
// - Sleep wake causes encode 000 watchdog, 010 pin reset, 110 pin change.
// - Power-up gives 011; awake watchdog clears pin-wake and timeout only.
// - Flags hold until a reset or sleep; awake pin reset clears only pin-wake.
// - Sleep sets the timeout flag and clears the powerdown flag.
// - Waking from sleep clears the watchdog counter.
// - Pin-wake is set when, asleep with wake enabled, a pin differs from its last read.
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module rdw_reset_watchdog #(
    parameter int unsigned POR_DELAY_CYC = rdw_pkg::POR_DELAY_CYC,
    parameter int unsigned SUB_DELAY_CYC = rdw_pkg::SUB_DELAY_CYC,
    parameter int unsigned WDT_CYC = rdw_pkg::WDT_CYC,
    parameter int unsigned PIN_N = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rdw_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic shared_input_pin,
    input wire logic reset_pin_fuse,
    input wire logic watchdog_fuse,
    input wire logic clear_watchdog_op,
    input wire logic sleep_op,
    input wire logic port_access,
    input wire logic [PIN_N-1:0] wake_pins,
    output logic core_reset,
    output logic gpio_shared_in,
    output logic asleep,
    output logic timeout_flag_n,
    output logic powerdown_flag_n,
    output logic pin_wake_flag
);
    localparam int unsigned DLY_W = $clog2(POR_DELAY_CYC + 1);
    localparam int unsigned WDT_W = $clog2(WDT_CYC + 1);
    localparam logic [DLY_W-1:0] POR_LAST = DLY_W'(POR_DELAY_CYC - 1);
    localparam logic [DLY_W-1:0] SUB_LAST = DLY_W'(SUB_DELAY_CYC - 1);
    localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_CYC - 1);

    // Refuse counts that the counters cannot serve
    if (SUB_DELAY_CYC < 1 || SUB_DELAY_CYC > POR_DELAY_CYC
        || WDT_CYC < 2 || PIN_N < 1) begin : g_bad_params
        $error("rdw_reset_watchdog: unsupported parameter values");
    end

    // Prescaler terminal count: ratio minus one, zero when not assigned
    function automatic logic [rdw_pkg::PRESC_W-1:0] presc_limit(input logic [7:0] opt);
        logic [rdw_pkg::PRESC_W:0] ratio;
        ratio = '0;
        if (opt[rdw_pkg::OPT_PSA_BIT]) begin
            ratio = (rdw_pkg::PRESC_W+1)'(1) << opt[rdw_pkg::OPT_PS_LSB +: rdw_pkg::PS_W];
        end else begin
            ratio = (rdw_pkg::PRESC_W+1)'(1);
        end
        return rdw_pkg::PRESC_W'(ratio - (rdw_pkg::PRESC_W+1)'(1));
    endfunction

    logic latch_reg;
    logic por_pend_reg;
    logic [DLY_W-1:0] dly_cnt_reg;
    logic ext_prev_reg;
    logic asleep_reg;
    logic [WDT_W-1:0] wdt_cnt_reg;
    logic [rdw_pkg::PRESC_W-1:0] presc_reg;
    logic [7:0] opt_reg;
    logic to_n_reg;
    logic pd_n_reg;
    logic pw_reg;
    logic [PIN_N-1:0] snap_reg;
    logic gpio_reg;
    logic [31:0] prdata_reg;

    logic latch_next;
    logic por_pend_next;
    logic [DLY_W-1:0] dly_cnt_next;
    logic [WDT_W-1:0] wdt_cnt_next;
    logic [rdw_pkg::PRESC_W-1:0] presc_next;
    logic [7:0] opt_next;
    logic to_n_next;
    logic pd_n_next;
    logic pw_next;
    logic asleep_next;

    wire ext_eff_n = reset_pin_fuse ? shared_input_pin : 1'b1;
    wire ext_fall = ext_prev_reg & ~ext_eff_n;

    wire running = ~latch_reg & ~asleep_reg;
    wire [DLY_W-1:0] dly_last = por_pend_reg ? POR_LAST : SUB_LAST;
    wire dly_done = latch_reg & ext_eff_n & (dly_cnt_reg == dly_last);

    wire wake_en = ~opt_reg[rdw_pkg::OPT_WAKE_DIS_BIT];
    wire pin_evt = asleep_reg & ~latch_reg & wake_en & ((wake_pins ^ snap_reg) != '0);

    wire wdt_active = watchdog_fuse & ~latch_reg;
    wire presc_tick = presc_reg == presc_limit(opt_reg);
    wire wdt_fire = wdt_active & presc_tick & (wdt_cnt_reg == WDT_LAST);

    wire any_evt = ext_fall | wdt_fire | pin_evt;
    wire sleep_acc = sleep_op & running & ~wdt_fire & ext_eff_n;
    wire clr_acc = clear_watchdog_op & running;

    // APB decode
    wire acc = psel & penable;
    wire hit_opt = paddr == rdw_pkg::OPT_ADDR;
    wire hit_stat = paddr == rdw_pkg::STAT_ADDR;
    wire unmapped = ~hit_opt & ~hit_stat;
    wire opt_wr = acc & pwrite & hit_opt & ~latch_reg;

    wire [31:0] stat_word = (32'h1 << rdw_pkg::STAT_PW_BIT) * pw_reg
        | (32'h1 << rdw_pkg::STAT_TO_BIT) * to_n_reg
        | (32'h1 << rdw_pkg::STAT_PD_BIT) * pd_n_reg
        | (32'h1 << rdw_pkg::STAT_SLEEP_BIT) * asleep_reg
        | (32'h1 << rdw_pkg::STAT_RST_BIT) * latch_reg;
    wire [31:0] rd_word = hit_stat ? stat_word : 32'h0;

    // Reset latch and delay counter
    always_comb begin
        latch_next = latch_reg;
        por_pend_next = por_pend_reg;
        dly_cnt_next = dly_cnt_reg;
        if (!ext_eff_n || any_evt) begin
            latch_next = 1'b1;
            dly_cnt_next = '0;
        end else if (dly_done) begin
            latch_next = 1'b0;
            por_pend_next = 1'b0;
            dly_cnt_next = '0;
        end else if (latch_reg) begin
            dly_cnt_next = DLY_W'(dly_cnt_reg + DLY_W'(1));
        end
    end

    // Watchdog counter and prescaler
    always_comb begin
        wdt_cnt_next = wdt_cnt_reg;
        presc_next = presc_reg;
        if (!wdt_active || any_evt) begin
            wdt_cnt_next = '0;
            presc_next = '0;
        end else if (clr_acc || sleep_acc) begin
            wdt_cnt_next = '0;
            presc_next = '0;
        end else if (presc_tick) begin
            presc_next = '0;
            wdt_cnt_next = WDT_W'(wdt_cnt_reg + WDT_W'(1));
        end else begin
            presc_next = rdw_pkg::PRESC_W'(presc_reg + rdw_pkg::PRESC_W'(1));
        end
    end

    // Reset-cause flags; a cause in the same cycle as sleep wins
    always_comb begin
        to_n_next = to_n_reg;
        pd_n_next = pd_n_reg;
        pw_next = pw_reg;
        asleep_next = asleep_reg;
        if (any_evt) begin
            asleep_next = 1'b0;
            if (wdt_fire) begin
                to_n_next = 1'b0;
            end else if (asleep_reg) begin
                to_n_next = 1'b1;
            end
            if (asleep_reg) begin
                pd_n_next = 1'b0;
            end
            // Awake pin reset clears pin-wake only
            pw_next = pin_evt & ~wdt_fire & ~ext_fall;
        end else if (sleep_acc) begin
            to_n_next = 1'b1;
            pd_n_next = 1'b0;
            asleep_next = 1'b1;
        end
    end

    always_comb begin
        opt_next = opt_reg;
        if (any_evt || dly_done) begin
            opt_next = opt_reg;
        end
        if (opt_wr) begin
            opt_next = pwdata[7:0];
        end
        if (latch_reg) begin
            opt_next = rdw_pkg::OPT_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latch_reg <= 1'b1;
            por_pend_reg <= 1'b1;
            dly_cnt_reg <= '0;
            ext_prev_reg <= 1'b1;
        end else begin
            latch_reg <= latch_next;
            por_pend_reg <= por_pend_next;
            dly_cnt_reg <= dly_cnt_next;
            ext_prev_reg <= ext_eff_n;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_reg <= '0;
            presc_reg <= '0;
            opt_reg <= rdw_pkg::OPT_RESET;
            asleep_reg <= 1'b0;
        end else begin
            wdt_cnt_reg <= wdt_cnt_next;
            presc_reg <= presc_next;
            opt_reg <= opt_next;
            asleep_reg <= asleep_next;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            to_n_reg <= 1'b1;
            pd_n_reg <= 1'b1;
            pw_reg <= 1'b0;
        end else begin
            to_n_reg <= to_n_next;
            pd_n_reg <= pd_n_next;
            pw_reg <= pw_next;
        end
    end

    // Snapshot is the pin state software last read; stale snapshot wakes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            snap_reg <= '0;
            gpio_reg <= 1'b0;
        end else begin
            if (port_access) begin
                snap_reg <= wake_pins;
            end
            gpio_reg <= reset_pin_fuse ? 1'b0 : shared_input_pin;
        end
    end

    // Read data captured in the setup cycle, valid through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (psel && !penable) begin
            prdata_reg <= rd_word;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = acc & unmapped;
    assign core_reset = latch_reg;
    assign gpio_shared_in = gpio_reg;
    assign asleep = asleep_reg;
    assign timeout_flag_n = to_n_reg;
    assign powerdown_flag_n = pd_n_reg;
    assign pin_wake_flag = pw_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_tied_inactive;
        (!reset_pin_fuse && !core_reset && !wdt_fire && !pin_evt) |=> !core_reset;
    endproperty
    a_tied_inactive: assert property (p_tied_inactive)
        else $error("reset input not inactive with fuse programmed");

    property p_pin_low_holds;
        (reset_pin_fuse && !shared_input_pin) |=> (latch_reg && dly_cnt_reg == '0);
    endproperty
    a_pin_low_holds: assert property (p_pin_low_holds)
        else $error("low reset pin did not hold delay cleared");

    property p_release_at_count;
        $fell(latch_reg) |-> $past(dly_cnt_reg) == $past(dly_last);
    endproperty
    a_release_at_count: assert property (p_release_at_count)
        else $error("latch released at wrong delay count");

    property p_short_delay;
        (latch_reg && !por_pend_reg && ext_eff_n && !any_evt && dly_cnt_reg == SUB_LAST)
            |=> !core_reset;
    endproperty
    a_short_delay: assert property (p_short_delay)
        else $error("short delay did not end on time");

    property p_core_held;
        (dly_cnt_reg != '0) |-> core_reset;
    endproperty
    a_core_held: assert property (p_core_held)
        else $error("core out of reset while delay active");

    property p_wdt_to;
        wdt_fire |=> (!timeout_flag_n && core_reset && !pin_wake_flag);
    endproperty
    a_wdt_to: assert property (p_wdt_to)
        else $error("watchdog expiry did not clear timeout flag");

    property p_wdt_off;
        !watchdog_fuse |-> !wdt_fire;
    endproperty
    a_wdt_off: assert property (p_wdt_off)
        else $error("disabled watchdog fired");

    property p_clear_op;
        (clr_acc && !any_evt) |=> (wdt_cnt_reg == '0 && presc_reg == '0);
    endproperty
    a_clear_op: assert property (p_clear_op)
        else $error("clear op did not zero watchdog");

    property p_sleep_flags;
        sleep_acc |=> (timeout_flag_n && !powerdown_flag_n && asleep);
    endproperty
    a_sleep_flags: assert property (p_sleep_flags)
        else $error("sleep did not update flags");

    property p_pin_wake_code;
        (pin_evt && !wdt_fire && !ext_fall) |=> (pin_wake_flag && timeout_flag_n
            && !powerdown_flag_n && !asleep);
    endproperty
    a_pin_wake_code: assert property (p_pin_wake_code)
        else $error("pin change wake code wrong");

    property p_awake_pin_reset;
        (ext_fall && running && !wdt_fire) |=> (!pin_wake_flag
            && timeout_flag_n == $past(to_n_reg) && powerdown_flag_n == $past(pd_n_reg));
    endproperty
    a_awake_pin_reset: assert property (p_awake_pin_reset)
        else $error("awake pin reset changed wrong flags");

    property p_flags_hold;
        (!any_evt && !sleep_acc) |=> $stable(pin_wake_flag) && $stable(timeout_flag_n);
    endproperty
    a_flags_hold: assert property (p_flags_hold)
        else $error("flags changed without cause");
endmodule

// [logic/rdw_pkg.sv]
// Constants shared by the reset delay and watchdog block
package rdw_pkg;
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned POR_DELAY_NS = 1125000;
    localparam int unsigned SUB_DELAY_NS = 10000;
    localparam int unsigned WDT_PERIOD_NS = 18000000;
    localparam int unsigned POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SUB_DELAY_CYC = (SUB_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WDT_CYC = (WDT_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] OPT_ADDR = 8'h00;
    localparam logic [7:0] STAT_ADDR = 8'h04;

    localparam logic [7:0] OPT_RESET = 8'hff;
    localparam int unsigned OPT_WAKE_DIS_BIT = 7;
    localparam int unsigned OPT_PSA_BIT = 3;
    localparam int unsigned OPT_PS_LSB = 0;
    localparam int unsigned PS_W = 3;
    localparam int unsigned PRESC_W = 7;

    localparam int unsigned STAT_PW_BIT = 7;
    localparam int unsigned STAT_TO_BIT = 4;
    localparam int unsigned STAT_PD_BIT = 3;
    localparam int unsigned STAT_SLEEP_BIT = 1;
    localparam int unsigned STAT_RST_BIT = 0;
endpackage

// [verif/rdw_reset_watchdog_tb.sv]
// Self-checking testbench for the reset delay and watchdog block
`timescale 1ns/1ps
module rdw_reset_watchdog_tb;
    // Shortened counts keep the run brief; every expectation derives from them
    localparam int POR = 40;
    localparam int SUB = 5;
    localparam int WDT = 20;
    localparam int CEILING = 20000;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [rdw_pkg::ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic shared_input_pin = 1'b1;
    logic reset_pin_fuse = 1'b1;
    logic watchdog_fuse = 1'b1;
    logic clear_watchdog_op = 1'b0;
    logic sleep_op = 1'b0;
    logic port_access = 1'b0;
    logic [2:0] wake_pins = 3'h0;
    logic core_reset;
    logic gpio_shared_in;
    logic asleep;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic pin_wake_flag;
    int num_errors = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    logic [31:0] rd;
    logic err;

    rdw_reset_watchdog #(.POR_DELAY_CYC(POR), .SUB_DELAY_CYC(SUB), .WDT_CYC(WDT), .PIN_N(3)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .shared_input_pin(shared_input_pin), .reset_pin_fuse(reset_pin_fuse),
        .watchdog_fuse(watchdog_fuse), .clear_watchdog_op(clear_watchdog_op),
        .sleep_op(sleep_op), .port_access(port_access), .wake_pins(wake_pins),
        .core_reset(core_reset), .gpio_shared_in(gpio_shared_in), .asleep(asleep),
        .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
        .pin_wake_flag(pin_wake_flag)
    );

    always #50 pclk = ~pclk;

    always @(posedge pclk) begin
        cycles++;
        if (cycles == CEILING) begin
            num_errors++;
            final_report();
        end
    end

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic check1(input string name, input logic seen, input logic exp);
        check(name, {31'h0, seen}, {31'h0, exp});
    endtask

    // Order is pin-wake, timeout, powerdown
    task automatic flags(input logic [2:0] exp);
        check("flags", {29'h0, pin_wake_flag, timeout_flag_n, powerdown_flag_n}, {29'h0, exp});
    endtask

    task automatic in_range(input string name, input int v, input int lo, input int hi);
        check1(name, (v >= lo && v <= hi), 1'b1);
    endtask

    // Waits a full edge first so psel is never driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pulse(input int which);
        @(posedge pclk);
        case (which)
            0: clear_watchdog_op <= 1'b1;
            1: sleep_op <= 1'b1;
            default: port_access <= 1'b1;
        endcase
        @(posedge pclk);
        clear_watchdog_op <= 1'b0;
        sleep_op <= 1'b0;
        port_access <= 1'b0;
    endtask

    // Samples on the falling edge, where registered outputs have settled
    task automatic wait_lvl(input logic lvl, output int cnt);
        cnt = 0;
        while (core_reset !== lvl) begin
            @(negedge pclk);
            cnt++;
        end
    endtask

    task automatic pin_reset();
        @(posedge pclk);
        shared_input_pin <= 1'b0;
        repeat (2 * SUB) @(posedge pclk);
        @(negedge pclk);
        check1("held_while_low", core_reset, 1'b1);
        @(posedge pclk);
        shared_input_pin <= 1'b1;
        wait_lvl(1'b0, n);
        in_range("sub_delay", n, SUB, SUB + 4);
    endtask

    task automatic t_power_up();
        @(negedge pclk);
        check1("por_latch", core_reset, 1'b1);
        flags(3'b011);
        wait_lvl(1'b0, n);
        in_range("por_delay", n, POR - 2, POR + 2);
        apb(1'b0, rdw_pkg::STAT_ADDR, 32'h0);
        check("status_word", rd, 32'h18);
    endtask

    task automatic t_apb();
        apb(1'b0, rdw_pkg::OPT_ADDR, 32'h0);
        check("option_read", rd, 32'h0);
        apb(1'b1, 8'h08, 32'hff);
        check1("unmapped_err", err, 1'b1);
        check1("ready_level", pready, 1'b1);
        apb(1'b1, rdw_pkg::STAT_ADDR, 32'h0);
        apb(1'b0, rdw_pkg::STAT_ADDR, 32'h0);
        check("status_kept", rd, 32'h18);
    endtask

    task automatic t_wdt_awake();
        apb(1'b1, rdw_pkg::OPT_ADDR, 32'h0);
        repeat (10) begin
            pulse(0);
            repeat (8) @(posedge pclk);
        end
        @(negedge pclk);
        check1("cleared_in_time", core_reset, 1'b0);
        pulse(0);
        wait_lvl(1'b1, n);
        in_range("wdt_period", n, WDT - 2, WDT + 3);
        flags(3'b001);
        wait_lvl(1'b0, n);
        in_range("wdt_sub_delay", n, SUB - 1, SUB + 3);
    endtask

    task automatic t_prescale();
        for (int s = 0; s < 3; s++) begin
            apb(1'b1, rdw_pkg::OPT_ADDR, {29'h1, s[2:0]});
            pulse(0);
            wait_lvl(1'b1, n);
            in_range("wdt_ratio", n, (WDT << s) - 2, (WDT << s) + 3);
            wait_lvl(1'b0, n);
        end
    endtask

    task automatic t_sleep_wdt();
        apb(1'b1, rdw_pkg::OPT_ADDR, 32'h0);
        pulse(1);
        @(negedge pclk);
        check1("asleep", asleep, 1'b1);
        flags(3'b010);
        wait_lvl(1'b1, n);
        in_range("sleep_wdt", n, WDT - 3, WDT + 3);
        flags(3'b000);
        check1("woken", asleep, 1'b0);
        wait_lvl(1'b0, n);
    endtask

    task automatic t_sleep_pin();
        apb(1'b1, rdw_pkg::OPT_ADDR, 32'hff);
        pulse(2);
        pulse(1);
        wake_pins <= 3'h5;
        repeat (10) @(posedge pclk);
        wake_pins <= 3'h0;
        @(negedge pclk);
        check1("wake_disabled", asleep, 1'b1);
        pin_reset();
        flags(3'b010);
    endtask

    task automatic t_sleep_change();
        apb(1'b1, rdw_pkg::OPT_ADDR, 32'h0f);
        pulse(2);
        pulse(1);
        wake_pins <= 3'h1;
        wait_lvl(1'b1, n);
        in_range("change_wake", n, 1, 4);
        flags(3'b110);
        @(posedge pclk);
        wake_pins <= 3'h0;
        wait_lvl(1'b0, n);
        pin_reset();
        flags(3'b010);
    endtask

    task automatic t_fuses_off();
        @(posedge pclk);
        reset_pin_fuse <= 1'b0;
        watchdog_fuse <= 1'b0;
        shared_input_pin <= 1'b0;
        apb(1'b1, rdw_pkg::OPT_ADDR, 32'h0);
        repeat (3 * WDT) @(posedge pclk);
        shared_input_pin <= 1'b1;
        @(negedge pclk);
        check1("pin_no_reset", core_reset, 1'b0);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        check1("pin_as_gpio", gpio_shared_in, 1'b1);
        check1("wdt_disabled", core_reset, 1'b0);
        @(posedge pclk);
        reset_pin_fuse <= 1'b1;
        watchdog_fuse <= 1'b1;
        // The pin register already samples the new fuse at this edge
        @(posedge pclk);
        @(negedge pclk);
        check1("gpio_released", gpio_shared_in, 1'b0);
    endtask

    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_power_up();
        t_apb();
        t_wdt_awake();
        t_prescale();
        t_sleep_wdt();
        t_sleep_pin();
        t_sleep_change();
        t_fuses_off();
        final_report();
    end
endmodule
